// *** hdl/charge_state_defines.svh ***
// Purpose: Offsets, field positions and reset values for the charge
//          state controller.
// Assumes: APB with 32-bit data; every register is one aligned word.
// Notes:   Operation list below, one line per rule.
//
// Operation
// - In voltage regulation, end charge at set-pin 250 mV or 100 mV.
// - Set-pin 2.5 V is full current; termination same on both inputs.
// - After done, restart charging when output drops below recharge level.
// - Regulator on only while adapter or USB input is present.
// - Enable low with input present: regulator fed from battery.
// - No input: sleep, battery switch kept on to feed the system.
// - Input present, enable low: standby, input switches off, regulator on.
// - Enable high runs the device, low disables it; host drives it.
// - Status pins: pre on/on, fast on/off, done off/on, else off/off.
// - Power-good pulls low when input present above battery, off in sleep.
// - Output-droop mode cuts charge current and blocks termination.
// - Droop pin floating or driven high forces charge current to zero.
// - Fault above recharge level holds until battery drops, then restarts.
// - Power-on reset or enable toggle clears a latched timer fault.
// - Fault below recharge level: fault current on until battery rises.
// - Output under 1 V: input switches off, pull-ups on, until recovery (code: pull-ups stay off in standby).
// - Output 200 mV under battery: battery switch off, 10 mA source on.
// - Droop pin under 1 V suppresses battery short-circuit protection.
// - Safety timer expiry before termination stops charger, shows fault.
// - Thermal regulation disables termination detection.
`ifndef CHARGE_STATE_DEFINES_SVH
`define CHARGE_STATE_DEFINES_SVH

// Register map (byte addresses)
`define CSC_ADDR_W 8
`define CSC_CTRL_OFF 8'h00
`define CSC_STATUS_OFF 8'h04

// Control fields and reset value
`define CSC_CTRL_TERM_SEL 0
`define CSC_CTRL_RESET 1'h0

// Status fields
`define CSC_ST_STATE_LSB 0
`define CSC_ST_FAULT 3
`define CSC_ST_FAULT_BELOW 4
`define CSC_ST_OUT_SHORT 5
`define CSC_ST_BAT_SHORT 6
`define CSC_ST_ENABLE 7

// Synchronised input vector positions
`define SYN_W 18
`define SYN_CE 0
`define SYN_AC_PRESENT 1
`define SYN_USB_PRESENT 2
`define SYN_AC_ABOVE_BAT 3
`define SYN_USB_ABOVE_BAT 4
`define SYN_SET_BELOW_250 5
`define SYN_SET_BELOW_100 6
`define SYN_VREG_PHASE 7
`define SYN_OUT_BELOW_RCH 8
`define SYN_BAT_BELOW_LOWV 9
`define SYN_OUT_BELOW_1V 10
`define SYN_OUT_BELOW_BAT 11
`define SYN_DROOP_ACTIVE 12
`define SYN_DROOP_PIN_HIGH 13
`define SYN_DROOP_BELOW_1V 14
`define SYN_THERMAL_REG 15
`define SYN_TEMP_SUSPEND 16
`define SYN_TIMER_EXPIRED 17

`endif

// *** hdl/charge_state_pkg.sv ***
// Purpose: Types shared by the charge state controller.
// Assumes: Nothing beyond the defines header.
// Notes:   States use Gray codes along pre, fast, done.
package charge_state_pkg;

  // Charger states
  typedef enum logic [2:0] {
    S_SLEEP = 3'h0,
    S_PRE = 3'h1,
    S_FAST = 3'h3,
    S_DONE = 3'h2,
    S_FAULT = 3'h6,
    S_STANDBY = 3'h4
  } chg_state_t;

endpackage : charge_state_pkg

// *** hdl/comparator_sync_if.sv ***
// Purpose: Carries raw and synchronised comparator levels.
// Assumes: One clock domain.
// Notes:   Width is a parameter.
`timescale 1ns/1ps
`default_nettype none

interface comparator_sync_if #(parameter int W = 18);
  logic [W-1:0] raw;
  logic [W-1:0] synced;
  modport src (output raw, input synced);
  modport sync (input raw, output synced);
endinterface : comparator_sync_if

`default_nettype wire

// *** hdl/comparator_sync.sv ***
// Purpose: Two-flop synchroniser bank for comparator decisions.
// Assumes: Reset already synchronised to i_clock.
// Notes:   First stage is read only by the second stage.
`timescale 1ns/1ps
`default_nettype none

module comparator_sync #(
  parameter int W = 18
) (
  input wire logic i_clock, // System clock
  input wire logic i_rst_n, // Synchronised reset
  comparator_sync_if.sync bus // Raw in, synced out
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  ////////////////////////////////////////////////////////////////////////////
  // One two-stage chain per bit
  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      always_ff @(posedge i_clock or negedge i_rst_n)
      begin
        if (!i_rst_n)
        begin
          meta_ff[g] <= 1'h0;
          sync_ff[g] <= 1'h0;
        end
        else
        begin
          meta_ff[g] <= bus.raw[g];
          sync_ff[g] <= meta_ff[g];
        end
      end
    end
  endgenerate

  // Synchronised levels out
  assign bus.synced = sync_ff;

endmodule : comparator_sync

`default_nettype wire

// *** hdl/charge_state_control.sv ***
// Purpose: Charge state control, power-path switches and status pins.
// Assumes: Comparator inputs are levels from analog decisions.
// Notes:   APB slave answers with one wait state.
//
// The implementer's own choices: the placing of the registers and register access over APB.
`include "charge_state_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module charge_state_control
  import charge_state_pkg::*;
(
  input wire logic i_clock, // 40 MHz clock
  input wire logic i_arst_n, // Async reset, active low
  // APB slave
  input wire logic i_psel, // Slave select
  input wire logic i_penable, // Access phase
  input wire logic i_pwrite, // Write when high
  input wire logic [`CSC_ADDR_W-1:0] i_paddr, // Byte address
  input wire logic [31:0] i_pwdata, // Write data
  output logic [31:0] o_prdata, // Read data
  output logic o_pready, // Transfer done
  output logic o_pslverr, // Unmapped address
  // Host and comparator decisions
  input wire logic i_chip_enable, // Enable pin, high runs
  input wire logic i_ac_present, // Adapter present
  input wire logic i_usb_present, // USB present
  input wire logic i_ac_above_bat, // Adapter above battery
  input wire logic i_usb_above_bat, // USB above battery
  input wire logic i_set_below_250mv, // Set pin under 250 mV
  input wire logic i_set_below_100mv, // Set pin under 100 mV
  input wire logic i_vreg_phase, // Battery at regulation voltage
  input wire logic i_out_below_recharge, // Output under recharge level
  input wire logic i_bat_below_lowv, // Battery in precharge range
  input wire logic i_out_below_1v, // Output under 1 V
  input wire logic i_out_below_bat, // Output 200 mV under battery
  input wire logic i_droop_active, // Output-droop regulation on
  input wire logic i_droop_pin_high, // Droop pin floating or high
  input wire logic i_droop_below_1v, // Droop pin under 1 V
  input wire logic i_thermal_reg, // Junction thermal regulation
  input wire logic i_temp_suspend, // Temperature suspend
  input wire logic i_timer_expired, // Safety timer expired
  // Power path
  output logic o_adapter_input_switch, // Adapter switch on
  output logic o_usb_input_switch, // USB switch on
  output logic o_battery_switch, // Battery switch on
  output logic o_ac_pullup, // Adapter 500 ohm pull-up on
  output logic o_usb_pullup, // USB 500 ohm pull-up on
  output logic o_bat_recovery_src, // 10 mA recovery source on
  output logic o_ldo_enable, // Regulator on
  output logic o_ldo_from_battery, // Regulator fed by battery
  output logic o_charge_enable, // Charger running
  output logic o_charge_force_zero, // Charge current forced to zero
  output logic o_fault_current, // Fault-detect current on
  // Open-drain status pins, enable low drives low
  output logic o_status_out_first_o, // Pin data
  output logic o_status_out_first_oe_n, // Low pulls pin
  output logic o_status_out_second_o, // Pin data
  output logic o_status_out_second_oe_n, // Low pulls pin
  output logic o_adapter_power_good_o, // Pin data
  output logic o_adapter_power_good_oe_n, // Low pulls pin
  output logic o_usb_input_power_good_o, // Pin data
  output logic o_usb_input_power_good_oe_n // Low pulls pin
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flops
  logic rst_meta_ff;
  logic rst_n_ff;

  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rst_meta_ff <= 1'h0;
      rst_n_ff <= 1'h0;
    end
    else
    begin
      rst_meta_ff <= 1'h1;
      rst_n_ff <= rst_meta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  comparator_sync_if #(.W(`SYN_W)) cmp_if ();

  // Pack raw levels
  assign cmp_if.raw = {
    i_timer_expired, i_temp_suspend, i_thermal_reg, i_droop_below_1v,
    i_droop_pin_high, i_droop_active, i_out_below_bat, i_out_below_1v,
    i_bat_below_lowv, i_out_below_recharge, i_vreg_phase,
    i_set_below_100mv, i_set_below_250mv, i_usb_above_bat,
    i_ac_above_bat, i_usb_present, i_ac_present, i_chip_enable};

  comparator_sync #(.W(`SYN_W)) u_sync (
    .i_clock(i_clock),
    .i_rst_n(rst_n_ff),
    .bus(cmp_if.sync)
  );

  // Named synchronised levels
  wire logic [`SYN_W-1:0] syn = cmp_if.synced;
  wire logic ce = syn[`SYN_CE];
  wire logic ac_in = syn[`SYN_AC_PRESENT];
  wire logic usb_in = syn[`SYN_USB_PRESENT];
  wire logic out_below_rch = syn[`SYN_OUT_BELOW_RCH];
  wire logic out_short = syn[`SYN_OUT_BELOW_1V];
  wire logic droop_high = syn[`SYN_DROOP_PIN_HIGH];
  wire logic temp_susp = syn[`SYN_TEMP_SUSPEND];
  wire logic timer_exp = syn[`SYN_TIMER_EXPIRED];
  wire logic in_present = ac_in | usb_in;

  ////////////////////////////////////////////////////////////////////////////
  // APB register file
  logic term_sel_ff; // 0: tenth of C, 1: twenty-fifth of C
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  chg_state_t state_ff;
  logic fault_ff;
  logic fault_below_ff;
  logic bat_short_ff;

  // Address decode
  wire logic hit_ctrl = (i_paddr == `CSC_CTRL_OFF);
  wire logic hit_status = (i_paddr == `CSC_STATUS_OFF);
  wire logic mapped = hit_ctrl | hit_status;
  wire logic access = i_psel & i_penable;
  wire logic wr_take = access & pready_ff & i_pwrite & hit_ctrl;

  // Status word
  logic [31:0] status_word;
  always_comb
  begin
    status_word = 32'h0;
    status_word[`CSC_ST_STATE_LSB +: 3] = state_ff;
    status_word[`CSC_ST_FAULT] = fault_ff;
    status_word[`CSC_ST_FAULT_BELOW] = fault_below_ff;
    status_word[`CSC_ST_OUT_SHORT] = out_short;
    status_word[`CSC_ST_BAT_SHORT] = bat_short_ff;
    status_word[`CSC_ST_ENABLE] = ce;
  end

  // Read mux
  logic [31:0] rd_mux;
  always_comb
  begin
    if (hit_ctrl)
      rd_mux = {31'h0, term_sel_ff};
    else if (hit_status)
      rd_mux = status_word;
    else
      rd_mux = 32'h0;
  end

  // Bus handshake: one wait state, data and error with ready
  always_ff @(posedge i_clock or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      pready_ff <= 1'h0;
      pslverr_ff <= 1'h0;
      prdata_ff <= 32'h0;
    end
    else
    begin
      pready_ff <= access & ~pready_ff;
      pslverr_ff <= access & ~pready_ff & ~mapped;
      prdata_ff <= (access & ~pready_ff & ~i_pwrite) ? rd_mux : 32'h0;
    end
  end

  // Control register
  always_ff @(posedge i_clock or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
      term_sel_ff <= `CSC_CTRL_RESET;
    else if (wr_take)
      term_sel_ff <= i_pwdata[`CSC_CTRL_TERM_SEL];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Charge state machine
  chg_state_t nxt_state;
  logic nxt_fault;
  logic nxt_fault_below;

  // Termination hit, blocked by droop, thermal loop and forced zero
  wire logic set_at_term = term_sel_ff ? syn[`SYN_SET_BELOW_100]
                                       : syn[`SYN_SET_BELOW_250];
  wire logic term_hit = syn[`SYN_VREG_PHASE] & set_at_term
                        & ~syn[`SYN_DROOP_ACTIVE]
                        & ~syn[`SYN_THERMAL_REG]
                        & ~droop_high;
  wire chg_state_t start_state = syn[`SYN_BAT_BELOW_LOWV] ? S_PRE : S_FAST;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_fault = fault_ff;
    nxt_fault_below = fault_below_ff;
    if (!ce)
    begin
      nxt_fault = 1'h0;
      nxt_fault_below = 1'h0;
    end
    if (!in_present)
      nxt_state = S_SLEEP;
    else if (!ce)
      nxt_state = S_STANDBY;
    else
    begin
      case (state_ff)
        S_SLEEP, S_STANDBY:
          nxt_state = fault_ff ? S_FAULT : start_state;
        S_PRE, S_FAST:
          if (timer_exp)
          begin
            nxt_state = S_FAULT;
            nxt_fault = 1'h1;
            nxt_fault_below = out_below_rch;
          end
          else if (state_ff == S_PRE && !syn[`SYN_BAT_BELOW_LOWV])
            nxt_state = S_FAST;
          else if (state_ff == S_FAST && term_hit)
            nxt_state = S_DONE;
        S_DONE:
          if (out_below_rch)
            nxt_state = start_state;
        S_FAULT:
          if (fault_below_ff)
          begin
            if (!out_below_rch)
              nxt_fault_below = 1'h0;
          end
          else if (out_below_rch)
          begin
            nxt_fault = 1'h0;
            nxt_state = start_state;
          end
        default:
          nxt_state = S_SLEEP;
      endcase
    end
  end

  // State and fault latch
  always_ff @(posedge i_clock or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      state_ff <= S_SLEEP;
      fault_ff <= 1'h0;
      fault_below_ff <= 1'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      fault_ff <= nxt_fault;
      fault_below_ff <= nxt_fault_below;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power path and pin decode
  wire logic awake = (state_ff != S_SLEEP) && (state_ff != S_STANDBY);
  wire logic charging = (state_ff == S_PRE) || (state_ff == S_FAST);
  wire logic show = ce & ~temp_susp;
  wire logic nxt_bat_short = syn[`SYN_OUT_BELOW_BAT]
                             & ~syn[`SYN_DROOP_BELOW_1V];
  wire logic nxt_ac_sw = awake & ac_in & ~out_short;
  wire logic nxt_usb_sw = awake & ~ac_in & usb_in & ~out_short;
  wire logic nxt_ac_pu = awake & ac_in & out_short;
  wire logic nxt_usb_pu = awake & usb_in & out_short;
  wire logic nxt_ldo_en = in_present;
  wire logic nxt_ldo_bat = in_present & ~ce;
  wire logic nxt_chg_en = charging & ~droop_high & ~temp_susp;
  wire logic nxt_fault_cur = (state_ff == S_FAULT) & fault_below_ff
                             & out_below_rch;
  wire logic nxt_status_out_first_on = show & charging;
  wire logic nxt_status_out_second_on = show & ((state_ff == S_PRE)
                                    || (state_ff == S_DONE));
  wire logic nxt_adapter_power_good_on = (state_ff != S_SLEEP) & ac_in
                           & syn[`SYN_AC_ABOVE_BAT];
  wire logic nxt_usb_input_power_good_on = (state_ff != S_SLEEP) & usb_in
                            & syn[`SYN_USB_ABOVE_BAT];

  // Output flops, all off and released at reset
  logic ac_sw_ff;
  logic usb_sw_ff;
  logic bat_sw_ff;
  logic ac_pu_ff;
  logic usb_pu_ff;
  logic ldo_en_ff;
  logic ldo_bat_ff;
  logic chg_en_ff;
  logic force_zero_ff;
  logic fault_cur_ff;
  logic status_out_first_oe_n_ff;
  logic status_out_second_oe_n_ff;
  logic adapter_power_good_oe_n_ff;
  logic usb_input_power_good_oe_n_ff;
  logic od_data_ff;

  always_ff @(posedge i_clock or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      ac_sw_ff <= 1'h0;
      usb_sw_ff <= 1'h0;
      bat_sw_ff <= 1'h0;
      bat_short_ff <= 1'h0;
      ac_pu_ff <= 1'h0;
      usb_pu_ff <= 1'h0;
      ldo_en_ff <= 1'h0;
      ldo_bat_ff <= 1'h0;
      chg_en_ff <= 1'h0;
      force_zero_ff <= 1'h0;
      fault_cur_ff <= 1'h0;
      status_out_first_oe_n_ff <= 1'h1;
      status_out_second_oe_n_ff <= 1'h1;
      adapter_power_good_oe_n_ff <= 1'h1;
      usb_input_power_good_oe_n_ff <= 1'h1;
      od_data_ff <= 1'h0;
    end
    else
    begin
      ac_sw_ff <= nxt_ac_sw;
      usb_sw_ff <= nxt_usb_sw;
      bat_sw_ff <= ~nxt_bat_short;
      bat_short_ff <= nxt_bat_short;
      ac_pu_ff <= nxt_ac_pu;
      usb_pu_ff <= nxt_usb_pu;
      ldo_en_ff <= nxt_ldo_en;
      ldo_bat_ff <= nxt_ldo_bat;
      chg_en_ff <= nxt_chg_en;
      force_zero_ff <= droop_high;
      fault_cur_ff <= nxt_fault_cur;
      status_out_first_oe_n_ff <= ~nxt_status_out_first_on;
      status_out_second_oe_n_ff <= ~nxt_status_out_second_on;
      adapter_power_good_oe_n_ff <= ~nxt_adapter_power_good_on;
      usb_input_power_good_oe_n_ff <= ~nxt_usb_input_power_good_on;
      od_data_ff <= 1'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output ports
  assign o_prdata = prdata_ff;
  assign o_pready = pready_ff;
  assign o_pslverr = pslverr_ff;
  assign o_adapter_input_switch = ac_sw_ff;
  assign o_usb_input_switch = usb_sw_ff;
  assign o_battery_switch = bat_sw_ff;
  assign o_ac_pullup = ac_pu_ff;
  assign o_usb_pullup = usb_pu_ff;
  assign o_bat_recovery_src = bat_short_ff;
  assign o_ldo_enable = ldo_en_ff;
  assign o_ldo_from_battery = ldo_bat_ff;
  assign o_charge_enable = chg_en_ff;
  assign o_charge_force_zero = force_zero_ff;
  assign o_fault_current = fault_cur_ff;
  assign o_status_out_first_o = od_data_ff;
  assign o_status_out_first_oe_n = status_out_first_oe_n_ff;
  assign o_status_out_second_o = od_data_ff;
  assign o_status_out_second_oe_n = status_out_second_oe_n_ff;
  assign o_adapter_power_good_o = od_data_ff;
  assign o_adapter_power_good_oe_n = adapter_power_good_oe_n_ff;
  assign o_usb_input_power_good_o = od_data_ff;
  assign o_usb_input_power_good_oe_n = usb_input_power_good_oe_n_ff;

endmodule : charge_state_control

`default_nettype wire

// *** verif/charge_state_properties.sv ***
// Purpose: Concurrent checks on the charge state controller ports.
// Assumes: A level held 8 cycles has passed reset release and sync.
// Notes:   Bound to the top module at the foot of this file.
`timescale 1ns/1ps
`default_nettype none

module charge_state_properties (
  input wire logic i_clock, // Clock
  input wire logic i_arst_n, // Reset
  input wire logic i_psel, // APB select
  input wire logic i_penable, // APB access
  input wire logic i_chip_enable, // Enable pin
  input wire logic i_ac_present, // Adapter in
  input wire logic i_usb_present, // USB in
  input wire logic i_out_below_1v, // Output short
  input wire logic i_out_below_bat, // Battery short
  input wire logic i_droop_below_1v, // Droop pin low
  input wire logic i_droop_pin_high, // Droop pin high
  input wire logic o_pready, // APB done
  input wire logic o_ldo_enable, // Regulator
  input wire logic o_ldo_from_battery, // Regulator source
  input wire logic o_adapter_input_switch, // Adapter switch
  input wire logic o_usb_input_switch, // USB switch
  input wire logic o_battery_switch, // Battery switch
  input wire logic o_ac_pullup, // Adapter pull-up
  input wire logic o_bat_recovery_src, // Recovery source
  input wire logic o_charge_enable, // Charger on
  input wire logic o_charge_force_zero, // Zero current
  input wire logic o_status_out_first_oe_n, // Status one
  input wire logic o_status_out_second_oe_n, // Status two
  input wire logic o_adapter_power_good_oe_n, // Adapter good
  input wire logic o_usb_input_power_good_oe_n // USB good
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);

  ////////////////////////////////////////////////////////////////////////////
  // Supply presence, sleep and standby
  ldo_off_a: assert property ((!i_ac_present && !i_usb_present)[*8]
    |-> !o_ldo_enable) else $error("regulator on with no input");
  sleep_pg_a: assert property ((!i_ac_present && !i_usb_present)[*8]
    |-> o_adapter_power_good_oe_n && o_usb_input_power_good_oe_n)
    else $error("power good pulled in sleep");
  sleep_batt_a: assert property
    ((!i_ac_present && !i_usb_present && !i_out_below_bat)[*8]
    |-> o_battery_switch) else $error("battery switch off in sleep");
  standby_path_a: assert property
    (((i_ac_present || i_usb_present) && !i_chip_enable)[*8]
    |-> !o_adapter_input_switch && !o_usb_input_switch && o_ldo_enable
    && o_ldo_from_battery) else $error("standby power path wrong");
  ce_status_a: assert property (!i_chip_enable[*8]
    |-> o_status_out_first_oe_n && o_status_out_second_oe_n)
    else $error("status pulled while disabled");

  ////////////////////////////////////////////////////////////////////////////
  // Short-circuit handling and charge disable
  out_short_a: assert property ((i_out_below_1v && i_ac_present)[*8]
    |-> !o_adapter_input_switch && !o_usb_input_switch && o_ac_pullup)
    else $error("output short not handled");
  bat_short_a: assert property
    ((i_out_below_bat && !i_droop_below_1v)[*8]
    |-> !o_battery_switch && o_bat_recovery_src)
    else $error("battery short not handled");
  short_supp_a: assert property (i_droop_below_1v[*8]
    |-> o_battery_switch && !o_bat_recovery_src)
    else $error("battery short protection not suppressed");
  droop_zero_a: assert property (i_droop_pin_high[*8]
    |-> o_charge_force_zero && !o_charge_enable)
    else $error("charge current not forced to zero");

  ////////////////////////////////////////////////////////////////////////////
  // Register bus answer timing
  pready_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  pready_answer_a: assert property
    ((i_psel && i_penable && !$past(i_penable)) |=> o_pready)
    else $error("ready not one cycle after access");
endmodule : charge_state_properties

bind charge_state_control charge_state_properties u_props (
  .i_clock, .i_arst_n, .i_psel, .i_penable, .i_chip_enable, .i_ac_present,
  .i_usb_present, .i_out_below_1v, .i_out_below_bat, .i_droop_below_1v,
  .i_droop_pin_high, .o_pready, .o_ldo_enable, .o_ldo_from_battery,
  .o_adapter_input_switch, .o_usb_input_switch, .o_battery_switch,
  .o_ac_pullup, .o_bat_recovery_src, .o_charge_enable, .o_charge_force_zero,
  .o_status_out_first_oe_n, .o_status_out_second_oe_n,
  .o_adapter_power_good_oe_n, .o_usb_input_power_good_oe_n);

`default_nettype wire

// *** verif/status_host_model.sv ***
// Purpose: Host or LED side of the open-drain status and good pins.
// Assumes: Every pin has a pull-up on the host side.
// Notes:   A read level of 0 means the pin is ON.
`timescale 1ns/1ps
`default_nettype none

module status_host_model (
  input wire logic [3:0] i_pin_o, // Pin data from the device
  input wire logic [3:0] i_pin_oe_n, // Low pulls the pin
  output logic [3:0] o_pin_level // Level the host reads
);
  // Released pins rise to the pull-up level
  assign o_pin_level = i_pin_oe_n | i_pin_o;
endmodule : status_host_model

`default_nettype wire

// *** verif/charge_state_control_tb.sv ***
// Purpose: Self-checking bench for the charge state controller.
// Assumes: Outputs settle within 8 cycles.
// Notes:   Expected states are written into the sequence; st_pins gives their pin levels.
`include "charge_state_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module charge_state_control_tb;
  import charge_state_pkg::*;
  logic i_clock = 1'b0;
  logic i_arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, v;
  logic pready, pslverr, err;
  logic [`SYN_W-1:0] cmp = '0;
  logic [`SYN_W-1:0] nx = '0;
  logic [10:0] pw;
  logic [3:0] od_o, od_oe, pin;
  int seed = 58;
  int cyc = 0;
  int checked = 0;
  int n_fail = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Clock, design, host pins
  initial forever #12.5 i_clock = ~i_clock;

  charge_state_control u_dut (.i_clock(i_clock), .i_arst_n(i_arst_n),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_chip_enable(cmp[0]), .i_ac_present(cmp[1]),
    .i_usb_present(cmp[2]), .i_ac_above_bat(cmp[3]),
    .i_usb_above_bat(cmp[4]), .i_set_below_250mv(cmp[5]),
    .i_set_below_100mv(cmp[6]), .i_vreg_phase(cmp[7]),
    .i_out_below_recharge(cmp[8]), .i_bat_below_lowv(cmp[9]),
    .i_out_below_1v(cmp[10]), .i_out_below_bat(cmp[11]),
    .i_droop_active(cmp[12]), .i_droop_pin_high(cmp[13]),
    .i_droop_below_1v(cmp[14]), .i_thermal_reg(cmp[15]),
    .i_temp_suspend(cmp[16]), .i_timer_expired(cmp[17]),
    .o_adapter_input_switch(pw[0]), .o_usb_input_switch(pw[1]),
    .o_battery_switch(pw[2]), .o_ac_pullup(pw[3]), .o_usb_pullup(pw[4]),
    .o_bat_recovery_src(pw[5]), .o_ldo_enable(pw[6]),
    .o_ldo_from_battery(pw[7]), .o_charge_enable(pw[8]),
    .o_charge_force_zero(pw[9]), .o_fault_current(pw[10]),
    .o_status_out_first_o(od_o[0]), .o_status_out_first_oe_n(od_oe[0]),
    .o_status_out_second_o(od_o[1]), .o_status_out_second_oe_n(od_oe[1]),
    .o_adapter_power_good_o(od_o[2]), .o_adapter_power_good_oe_n(od_oe[2]),
    .o_usb_input_power_good_o(od_o[3]),
    .o_usb_input_power_good_oe_n(od_oe[3]));

  status_host_model u_host (.i_pin_o(od_o), .i_pin_oe_n(od_oe),
    .o_pin_level(pin));

  ////////////////////////////////////////////////////////////////////////////
  // Checking, bus and stimulus tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic stop_test;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  // Status pin levels {first, second} the host expects per state
  function automatic logic [1:0] st_pins(input chg_state_t s);
    case (s)
      S_PRE: return 2'b00;
      S_FAST: return 2'b01;
      S_DONE: return 2'b10;
      default: return 2'b11;
    endcase
  endfunction : st_pins

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge i_clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clock);
    penable <= 1'b1;
    do
    begin
      @(posedge i_clock);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1)
      n_fail++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic go;
    cmp <= nx;
    repeat (8) @(posedge i_clock);
  endtask : go

  task automatic cs(input chg_state_t s);
    apb(1'b0, `CSC_STATUS_OFF, 32'h0);
    chk(rd[2:0], s);
    chk({pin[0], pin[1]}, st_pins(s));
  endtask : cs

  // Hang guard
  always @(posedge i_clock)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      stop_test;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (20) @(posedge i_clock);
    chk(pw, 11'h0);
    chk(od_oe, 4'hf);
    i_arst_n <= 1'b1;
    repeat (3) @(posedge i_clock);
    go;
    chk(pw[6], 1'b0);
    chk(pw[2], 1'b1);
    chk(pin[3:2], 2'b11);
    apb(1'b0, `CSC_CTRL_OFF, 32'h0);
    chk(rd, 32'h0);
    v = $random(seed);
    apb(1'b1, `CSC_CTRL_OFF, v);
    apb(1'b0, `CSC_CTRL_OFF, 32'h0);
    chk(rd, {31'h0, v[0]});
    apb(1'b1, `CSC_CTRL_OFF, 32'h0);
    apb(1'b1, 8'h08 | (v[7:0] & 8'hf8), 32'h1);
    chk(err, 1'b1);
    apb(1'b0, `CSC_CTRL_OFF, 32'h0);
    chk(rd, 32'h0);
    // Stimulus words: bit n of nx drives synchroniser input n
    nx = 18'h30b;
    go;
    cs(S_PRE);
    chk(pw[8:6], 3'b101);
    chk(pw[0], 1'b1);
    chk(pin[2], 1'b0);
    nx = 18'h10b;
    go;
    cs(S_FAST);
    nx = 18'h80ab;
    go;
    cs(S_FAST);
    nx = 18'h10ab;
    go;
    cs(S_FAST);
    apb(1'b1, `CSC_CTRL_OFF, 32'h1);
    nx = 18'h0ab;
    go;
    cs(S_FAST);
    nx = 18'h0eb;
    go;
    cs(S_DONE);
    nx = 18'h10b;
    go;
    cs(S_FAST);
    nx = 18'h2010b;
    go;
    cs(S_FAULT);
    chk(pw[8], 1'b0);
    chk(pw[10], 1'b1);
    nx = 18'h0b;
    go;
    chk(pw[10], 1'b0);
    cs(S_FAULT);
    nx = 18'h10b;
    go;
    cs(S_FAST);
    nx = 18'h2000b;
    go;
    cs(S_FAULT);
    nx = 18'h0a;
    go;
    chk(pw[7:6], 2'b11);
    chk(pw[2:0], 3'b100);
    chk(pin[1:0], 2'b11);
    apb(1'b0, `CSC_STATUS_OFF, 32'h0);
    chk(rd[2:0], S_STANDBY);
    nx = 18'h0b;
    go;
    cs(S_FAST);
    nx = 18'h200b;
    go;
    chk(pw[9:8], 2'b10);
    nx = 18'h40f;
    go;
    chk(pw[1:0], 2'b00);
    chk(pw[4:3], 2'b11);
    nx = 18'h80f;
    go;
    chk(pw[0], 1'b1);
    chk(pw[5], 1'b1);
    chk(pw[2], 1'b0);
    nx = 18'h480f;
    go;
    chk(pw[5], 1'b0);
    chk(pw[2], 1'b1);
    nx = 18'h1d;
    go;
    chk(pw[1:0], 2'b10);
    chk(pin[3:2], 2'b01);
    nx = 18'h19;
    go;
    cs(S_SLEEP);
    chk(pw[6], 1'b0);
    chk(pin[3:2], 2'b11);
    stop_test;
  end
endmodule : charge_state_control_tb

`default_nettype wire
